/* File: rtl/slvc_pkg.sv */
// package: register map, field layouts and timing constants for the link register block
package slvc_pkg;

  // register byte offsets within the 4K block
  localparam logic [11:0] OFF_VC_HDR      = 12'h000;
  localparam logic [11:0] OFF_PVC_CAP1    = 12'h004;
  localparam logic [11:0] OFF_PVC_CAP2    = 12'h008;
  localparam logic [11:0] OFF_PVC_CTL     = 12'h00c;
  localparam logic [11:0] OFF_VC0_RCAP    = 12'h010;
  localparam logic [11:0] OFF_VC0_RCTL    = 12'h014;
  localparam logic [11:0] OFF_VC0_RSTS    = 12'h01a;
  localparam logic [11:0] OFF_VC1_RCAP    = 12'h01c;
  localparam logic [11:0] OFF_VC1_RCTL    = 12'h020;
  localparam logic [11:0] OFF_VC1_RSTS    = 12'h026;
  localparam logic [11:0] OFF_LINK_CAP    = 12'h084;
  localparam logic [11:0] OFF_LINK_CTL    = 12'h088;
  localparam logic [11:0] OFF_LINK_STS    = 12'h08a;
  localparam logic [11:0] OFF_CNTDN_CTL   = 12'h208;

  // capability header fields
  localparam logic [11:0] HDR_NEXT_PTR    = 12'h040;
  localparam logic [3:0]  HDR_VERSION     = 4'h1;
  localparam logic [15:0] HDR_CAP_ID      = 16'h0002;

  // reset values
  localparam logic [31:0] RST_PVC_CAP1    = 32'h0000_0001;
  localparam logic [31:0] RST_PVC_CAP2    = 32'h0000_0001;
  localparam logic [15:0] RST_PVC_CTL     = 16'h0000;
  localparam logic [31:0] RST_VC0_RCAP    = 32'h0000_0001;
  localparam logic [31:0] RST_VC0_RCTL    = 32'h8000_00ff;
  localparam logic [15:0] RST_VC0_RSTS    = 16'h0002;
  localparam logic [31:0] RST_VC1_RCAP    = 32'h0001_0001;
  localparam logic [31:0] RST_VC1_RCTL    = 32'h0100_0000;
  localparam logic [15:0] RST_VC1_RSTS    = 16'h0002;
  localparam logic [31:0] RST_LINK_CAP    = 32'h0000_2689;
  localparam logic [15:0] RST_LINK_CTL    = 16'h0000;
  localparam logic [15:0] RST_LINK_STS    = 16'h0001;
  localparam logic [31:0] RST_CNTDN_CTL   = 32'h0000_7cb0;

  // writable masks
  localparam logic [31:0] WM_PVC_CAP1     = 32'h0000_0007;
  localparam logic [15:0] WM_PVC_CTL      = 16'h000e;
  localparam logic [31:0] WM_VC_RCTL      = 32'h0f00_00fe;
  localparam logic [15:0] WM_LINK_CTL     = 16'h00c3;
  localparam logic [31:0] WM_CNTDN_CTL    = 32'hff27_ffff;
  localparam int          CNTDN_AGGR_BIT  = 21;

  // idle timing: unit time per fast training sequence, core clock period
  localparam int          FTS_UNIT_PS     = 4000;
  localparam int          CLK_PERIOD_PS   = 100000;
  localparam int          FTS_WIDTH       = 8;
  // longest time rounds down, at least one cycle
  localparam int          UNITS_PER_CYC   = CLK_PERIOD_PS / FTS_UNIT_PS;
  localparam int          AGGR_DIV        = 4;

  // register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } slvc_req_t;

  typedef enum logic [1:0] {IDLE_RUN, IDLE_WAIT, IDLE_L0S} slvc_idle_t;

endpackage : slvc_pkg

/* File: rtl/slvc_wreg.sv */
// byte-lane writable register with a write mask and reset value
`timescale 1ns/10ps
`default_nettype none
module slvc_wreg
  import slvc_pkg::*;
#(
  parameter int          WIDTH = 32,
  parameter logic [31:0] RSTV  = 32'h0000_0000,
  parameter logic [31:0] WMASK = 32'h0000_0000
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // write port
  input  wire logic             wrEn,
  input  wire logic [3:0]       wrBe,
  input  wire logic [31:0]      wrData,
  // stored value
  output logic      [WIDTH-1:0] value
);

  initial
  begin
    if (WIDTH != 16 && WIDTH != 32)
      $error("slvc_wreg width must be 16 or 32");
  end

  logic [31:0] value_r;
  logic [31:0] value_nxt;
  logic [31:0] laneMask;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      laneMask[i*8 +: 8] = {8{wrBe[i]}};
    value_nxt = value_r;
    if (wrEn)
      value_nxt = (value_r & ~(WMASK & laneMask)) | (wrData & WMASK & laneMask);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      value_r <= RSTV;
    else
      value_r <= value_nxt;
  end

  assign value = value_r[WIDTH-1:0];

endmodule // slvc_wreg
`default_nettype wire

/* File: rtl/slvc_idle_timer.sv */
// link idle timer deciding when to move from L0 into L0s
`timescale 1ns/10ps
`default_nettype none
module slvc_idle_timer
  import slvc_pkg::*;
#(
  parameter int FTS_W = FTS_WIDTH
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // control
  input  wire logic             aggrEn,
  input  wire logic [FTS_W-1:0] ftsRequired,
  input  wire logic             linkIdle,
  // result
  output logic                  enterL0s
);

  localparam int CW = FTS_W + 1;

  slvc_idle_t     state_r;
  slvc_idle_t     state_nxt;
  logic [CW-1:0]  count_r;
  logic [CW-1:0]  count_nxt;
  logic [CW-1:0]  target;
  logic [CW-1:0]  fullWait;
  logic           enter_r;
  logic           enter_nxt;

  always_comb
  begin
    // fts count x 4ns in core cycles, rounded down, at least one
    fullWait = CW'(ftsRequired / UNITS_PER_CYC);
    if (aggrEn)
      fullWait = fullWait / CW'(AGGR_DIV);
    if (fullWait == '0)
      fullWait = CW'(1);
    target = fullWait;
  end

  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    enter_nxt = 1'b0;
    unique case (state_r)
      IDLE_RUN:
      begin
        count_nxt = '0;
        if (linkIdle)
          state_nxt = IDLE_WAIT;
      end
      IDLE_WAIT:
      begin
        if (!linkIdle)
          state_nxt = IDLE_RUN;
        else if (count_r + CW'(1) >= target)
        begin
          state_nxt = IDLE_L0S;
          enter_nxt = 1'b1;
        end
        else
          count_nxt = count_r + CW'(1);
      end
      IDLE_L0S:
      begin
        enter_nxt = linkIdle;
        if (!linkIdle)
          state_nxt = IDLE_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= IDLE_RUN;
      count_r <= '0;
      enter_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      enter_r <= enter_nxt;
    end
  end

  assign enterL0s = enter_r;

endmodule // slvc_idle_timer
`default_nettype wire

/* File: rtl/slvc_regs.sv */
// register block for the chip-to-chip link: vc capability, link and countdown control
//
// Summary of operation
// - normal L0s entry waits fts count times 4ns
// - aggressive entry waits one quarter of that
// - aggressive bit read/write, resets zero, runtime changeable
// - header bits 31:20 read next pointer 040h
// - header bits 19:16 read version 1
// - header bits 15:0 read capability id 0002h
// - vc capability sits at offset zero
`timescale 1ns/10ps
`default_nettype none
module slvc_regs
  import slvc_pkg::*;
#(
  parameter int FTS_W = FTS_WIDTH
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // register access
  input  wire slvc_req_t        req,
  output logic                  rdValid,
  output logic [31:0]           rdData,
  // link side
  input  wire logic [FTS_W-1:0] ftsRequired,
  input  wire logic             linkIdle,
  output logic                  enterL0s,
  output logic                  aggrL0sEn
);

  initial
  begin
    if (FTS_W < 1 || FTS_W > 16)
      $error("slvc_regs fts width out of range");
  end

  logic [31:0] pvcCap1;
  logic [15:0] pvcCtl;
  logic [31:0] vc0Rctl;
  logic [31:0] vc1Rctl;
  logic [15:0] linkCtl;
  logic [31:0] cntdnCtl;
  logic [31:0] vcHeader;
  logic [31:0] rdWord;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic        rdValid_r;
  logic        rdValid_nxt;
  logic        aggr_r;
  logic        aggr_nxt;
  logic        wPvcCap1;
  logic        wPvcCtl;
  logic        wVc0;
  logic        wVc1;
  logic        wLink;
  logic        wCntdn;
  logic [11:0] wordAddr;

  // word aligned decode; 16-bit registers at +2 use upper lanes
  assign wordAddr = {req.addr[11:2], 2'b00};
  assign wPvcCap1 = req.wr && wordAddr == OFF_PVC_CAP1;
  assign wPvcCtl  = req.wr && wordAddr == OFF_PVC_CTL;
  assign wVc0     = req.wr && wordAddr == OFF_VC0_RCTL;
  assign wVc1     = req.wr && wordAddr == OFF_VC1_RCTL;
  assign wLink    = req.wr && wordAddr == OFF_LINK_CTL;
  assign wCntdn   = req.wr && wordAddr == OFF_CNTDN_CTL;

  assign vcHeader = {HDR_NEXT_PTR, HDR_VERSION, HDR_CAP_ID};

  slvc_wreg #(.WIDTH(32), .RSTV(RST_PVC_CAP1), .WMASK(WM_PVC_CAP1)) uPvcCap1 (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wrEn     (wPvcCap1),
    .wrBe     (req.be),
    .wrData   (req.wdata),
    .value    (pvcCap1)
  );

  slvc_wreg #(.WIDTH(16), .RSTV({16'h0000, RST_PVC_CTL}),
              .WMASK({16'h0000, WM_PVC_CTL})) uPvcCtl (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wrEn     (wPvcCtl),
    .wrBe     (req.be),
    .wrData   (req.wdata),
    .value    (pvcCtl)
  );

  slvc_wreg #(.WIDTH(32), .RSTV(RST_VC0_RCTL), .WMASK(WM_VC_RCTL)) uVc0Rctl (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wrEn     (wVc0),
    .wrBe     (req.be),
    .wrData   (req.wdata),
    .value    (vc0Rctl)
  );

  slvc_wreg #(.WIDTH(32), .RSTV(RST_VC1_RCTL), .WMASK(WM_VC_RCTL)) uVc1Rctl (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wrEn     (wVc1),
    .wrBe     (req.be),
    .wrData   (req.wdata),
    .value    (vc1Rctl)
  );

  slvc_wreg #(.WIDTH(16), .RSTV({16'h0000, RST_LINK_CTL}),
              .WMASK({16'h0000, WM_LINK_CTL})) uLinkCtl (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wrEn     (wLink),
    .wrBe     (req.be),
    .wrData   (req.wdata),
    .value    (linkCtl)
  );

  // countdown control: aggressive bit writable any time, no link reset
  slvc_wreg #(.WIDTH(32), .RSTV(RST_CNTDN_CTL), .WMASK(WM_CNTDN_CTL)) uCntdn (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wrEn     (wCntdn),
    .wrBe     (req.be),
    .wrData   (req.wdata),
    .value    (cntdnCtl)
  );

  slvc_idle_timer #(.FTS_W(FTS_W)) uIdle (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .aggrEn      (cntdnCtl[CNTDN_AGGR_BIT]),
    .ftsRequired (ftsRequired),
    .linkIdle    (linkIdle),
    .enterL0s    (enterL0s)
  );

  // read mux; unlisted offsets return zero
  always_comb
  begin
    rdWord = 32'h0000_0000;
    unique case (wordAddr)
      OFF_VC_HDR:    rdWord = vcHeader;
      OFF_PVC_CAP1:  rdWord = pvcCap1;
      OFF_PVC_CAP2:  rdWord = RST_PVC_CAP2;
      OFF_PVC_CTL:   rdWord = {16'h0000, pvcCtl};
      OFF_VC0_RCAP:  rdWord = RST_VC0_RCAP;
      OFF_VC0_RCTL:  rdWord = vc0Rctl | RST_VC0_RCTL & ~WM_VC_RCTL;
      {OFF_VC0_RSTS[11:2], 2'b00}: rdWord = {RST_VC0_RSTS, 16'h0000};
      OFF_VC1_RCAP:  rdWord = RST_VC1_RCAP;
      OFF_VC1_RCTL:  rdWord = vc1Rctl;
      {OFF_VC1_RSTS[11:2], 2'b00}: rdWord = {RST_VC1_RSTS, 16'h0000};
      OFF_LINK_CAP:  rdWord = RST_LINK_CAP;
      OFF_LINK_CTL:  rdWord = {RST_LINK_STS, linkCtl};
      OFF_CNTDN_CTL: rdWord = cntdnCtl;
      default:       rdWord = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    rdValid_nxt = req.rd;
    rdData_nxt  = req.rd ? rdWord : 32'h0000_0000;
    aggr_nxt    = cntdnCtl[CNTDN_AGGR_BIT];
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdValid_r <= 1'b0;
      rdData_r  <= 32'h0000_0000;
      aggr_r    <= 1'b0;
    end
    else
    begin
      rdValid_r <= rdValid_nxt;
      rdData_r  <= rdData_nxt;
      aggr_r    <= aggr_nxt;
    end
  end

  assign rdValid   = rdValid_r;
  assign rdData    = rdData_r;
  assign aggrL0sEn = aggr_r;

endmodule // slvc_regs
`default_nettype wire

/* File: verif/slvc_regs_checker.sv */
// assertion checker for the link register block
`timescale 1ns/10ps
`default_nettype none
module slvc_regs_checker
  import slvc_pkg::*;
#(
  parameter int FTS_W = FTS_WIDTH
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // register access
  input  wire slvc_req_t        req,
  input  wire logic             rdValid,
  input  wire logic [31:0]      rdData,
  // link side
  input  wire logic [FTS_W-1:0] ftsRequired,
  input  wire logic             linkIdle,
  input  wire logic             enterL0s,
  input  wire logic             aggrL0sEn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  int idleCnt;
  int waitCyc;
  // expected idle wait in core cycles
  always_comb
  begin
    waitCyc = int'(ftsRequired) / UNITS_PER_CYC;
    if (waitCyc < 1) waitCyc = 1;
    if (aggrL0sEn) waitCyc = (waitCyc / AGGR_DIV < 1) ? 1 : waitCyc / AGGR_DIV;
  end
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) idleCnt <= 0;
    else idleCnt <= linkIdle ? ((idleCnt < 1000) ? idleCnt + 1 : idleCnt) : 0;
  sequence rdTaken; req.rd; endsequence
  sequence hdrRead; req.rd && req.addr[11:2] == 10'h000; endsequence
  sequence aggrWrite; req.wr && req.addr[11:2] == OFF_CNTDN_CTL[11:2] && req.be[2]; endsequence
  a_rd_answer: assert property (rdTaken |=> rdValid)
    else $error("read not answered");
  a_no_spurious: assert property (!req.rd |=> !rdValid)
    else $error("read valid without request");
  a_idle_zero: assert property (!rdValid |-> rdData == 32'h0)
    else $error("read data not zero while idle");
  a_hdr_next_ptr: assert property (hdrRead |=> rdData[31:20] == HDR_NEXT_PTR)
    else $error("header next pointer wrong");
  a_hdr_version: assert property (hdrRead |=> rdData[19:16] == HDR_VERSION)
    else $error("header version wrong");
  a_hdr_cap_id: assert property (hdrRead |=> rdData[15:0] == HDR_CAP_ID)
    else $error("header capability id wrong");
  a_reserved_zero: assert property (req.rd && req.addr >= 12'h300 |=> rdData == 32'h0)
    else $error("reserved offset not zero");
  a_aggr_copy: assert property (aggrWrite |=> ##1 aggrL0sEn == $past(req.wdata[21], 2))
    else $error("aggressive enable not following write");
  a_idle_drop: assert property (!linkIdle |=> !enterL0s)
    else $error("L0s held without idle");
  a_wait_early: assert property (enterL0s |-> idleCnt > waitCyc)
    else $error("L0s entered too early");
  a_wait_late: assert property (linkIdle && idleCnt == waitCyc + 2 |=> enterL0s)
    else $error("L0s entered too late");
endmodule // slvc_regs_checker
bind slvc_regs slvc_regs_checker #(.FTS_W(FTS_W)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .req(req), .rdValid(rdValid), .rdData(rdData),
  .ftsRequired(ftsRequired), .linkIdle(linkIdle), .enterL0s(enterL0s),
  .aggrL0sEn(aggrL0sEn));
`default_nettype wire

/* File: verif/slvc_link_model.sv */
// far-end link partner: fixed fts count and idle indication
`timescale 1ns/10ps
`default_nettype none
module slvc_link_model
  import slvc_pkg::*;
#(
  parameter int FTS_W = FTS_WIDTH,
  parameter int FTS   = 200
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // bench control
  input  wire logic             idleReq,
  // link side
  output logic      [FTS_W-1:0] ftsRequired,
  output logic                  linkIdle
);
  // never idle while held in reset
  assign linkIdle    = rstn & idleReq;
  assign ftsRequired = FTS_W'(FTS);
endmodule // slvc_link_model
`default_nettype wire

/* File: verif/test_serial_link_vc_register_block.sv */
// self-checking bench for the link register block
`timescale 1ns/10ps
`default_nettype none
module test_serial_link_vc_register_block
  import slvc_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d;} slvc_row_t;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        idleReq  = 1'b0;
  slvc_req_t   req      = '0;
  logic        rdValid, enterL0s, aggrL0sEn, linkIdle;
  logic [31:0] rdData;
  logic [7:0]  ftsRequired;
  int          num_errors = 0;
  int          num_checks = 0;
  slvc_row_t   rows [15] = '{'{12'h000, 32'h0401_0002}, '{12'h004, 32'h1}, '{12'h008, 32'h1},
    '{12'h00c, 32'h0}, '{12'h010, 32'h1}, '{12'h014, 32'h8000_00ff}, '{12'h018, 32'h0002_0000},
    '{12'h01c, 32'h0001_0001}, '{12'h020, 32'h0100_0000}, '{12'h024, 32'h0002_0000},
    '{12'h084, 32'h0000_2689}, '{12'h088, 32'h0001_0000}, '{12'h208, RST_CNTDN_CTL},
    '{12'h040, 32'h0}, '{12'hffc, 32'h0}};
  always #50 core_clk = ~core_clk;
  slvc_regs DUT (.core_clk(core_clk), .rstn(rstn), .req(req), .rdValid(rdValid),
    .rdData(rdData), .ftsRequired(ftsRequired), .linkIdle(linkIdle), .enterL0s(enterL0s),
    .aggrL0sEn(aggrL0sEn));
  slvc_link_model u_link (.core_clk(core_clk), .rstn(rstn), .idleReq(idleReq),
    .ftsRequired(ftsRequired), .linkIdle(linkIdle));
  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge core_clk);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, be: 4'hf, wdata: d};
    @(negedge core_clk);
    req = '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge core_clk);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'h0, wdata: 32'h0};
    @(negedge core_clk);
    // answer stands for one cycle after the taking edge
    chk({31'h0, rdValid}, 32'h1);
    chk(rdData, e);
    req = '0;
  endtask
  // idle until L0s entry, then release and see it drop
  task automatic idle_run(input int w);
    int n;
    n = 0;
    @(negedge core_clk);
    idleReq = 1'b1;
    while (enterL0s !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, n >= w + 1 && n <= w + 2}, 32'h1);
    if (n >= 40) end_sim();
    idleReq = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({31'h0, enterL0s}, 32'h0);
  endtask
  initial
  begin
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    foreach (rows[i]) rd(rows[i].a, rows[i].d);
    wr(OFF_VC_HDR, 32'hffff_ffff);
    rd(OFF_VC_HDR, 32'h0401_0002);
    wr(12'h300, 32'hffff_ffff);
    rd(12'h300, 32'h0);
    idle_run(8);
    wr(OFF_CNTDN_CTL, 32'hffff_ffff);
    rd(OFF_CNTDN_CTL, 32'hff27_ffff);
    chk({31'h0, aggrL0sEn}, 32'h1);
    idle_run(2);
    wr(OFF_CNTDN_CTL, 32'h0);
    rd(OFF_CNTDN_CTL, 32'h0);
    idle_run(8);
    // mid-run reset clears the aggressive bit
    wr(OFF_CNTDN_CTL, 32'hffff_ffff);
    repeat (2) @(negedge core_clk);
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({31'h0, aggrL0sEn}, 32'h0);
    rstn = 1'b1;
    rd(OFF_CNTDN_CTL, RST_CNTDN_CTL);
    chk({31'h0, aggrL0sEn}, 32'h0);
    idle_run(8);
    end_sim();
  end
endmodule // test_serial_link_vc_register_block
`default_nettype wire
